// ==== rtl/asp_regs.vh ====
/*
  Constants for the converter serial port: bit counts, timing figures.
  Assumes inclusion by the serial port module and its result store.
*/
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

// Configuration word length after the start bit
`define ASP_CFG_BITS 3
// Result width
`define ASP_RES_BITS 8
// Falling edges after start bit until the data line is taken
`define ASP_TURN_EDGE 4
// Wake-up interval in ns and system clock period in ns
`define ASP_WAKE_NS 10000
`define ASP_CLK_NS 50
`define ASP_WAKE_CYC ((`ASP_WAKE_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
// Configuration field positions
`define ASP_CFG_MODE 2
`define ASP_CFG_ODD 1
`define ASP_CFG_ORDER 0
// Config bits already counted when the last one arrives
`define ASP_CFG_LAST 2'h2
// Falls already counted when the line-taking fall arrives (ASP_TURN_EDGE less one)
`define ASP_TAKE_FALLS 4'h3
// Result bit counts: end of the MSB-first run, end of the trailing LSB-first run
`define ASP_OUT_MSB_END 5'h08
`define ASP_OUT_ALL_END 5'h0f

`endif

// ==== rtl/asp_result_reg.v ====
/*
  Result holder: latches the conversion word when the conversion starts
  and presents one bit, chosen by index, from a register.
  Assumes a single clock domain shared with the serial port.
*/
`timescale 1ns/1ps
`include "asp_regs.vh"

module asp_result_reg (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire load_in,
  input wire [7:0] data_in,
  input wire [2:0] idx_in,
  output reg bit_out
);
  reg [7:0] word_r;

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_r <= 8'h00;
      bit_out <= 1'b0;
    end else begin
      if (load_in) begin
        word_r <= data_in;
      end
      bit_out <= word_r[idx_in];
    end
  end
endmodule

// ==== rtl/asp_serial_port.v ====
/*
  Serial control port and power gating of a small sampling converter.
  Assumes the host supplies select, clock and data pins, asynchronous to
  clk_sys_in; the result word comes from the analog core on adc_result_in.
  Each sclk_in phase must last several clk_sys_in periods.
*/
`timescale 1ns/1ps
`include "asp_regs.vh"

module asp_serial_port (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire sel_b_in,
  input wire sclk_in,
  input wire sdata_in,
  input wire [7:0] adc_result_in,
  output reg sdata_out,
  output reg sdata_oe_out,
  output wire awake_out,
  output reg conv_start_out,
  output reg single_or_differential_out,
  output reg odd_sign_out,
  output reg first_bit_order_out
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  reg [1:0] sel_s_r;
  reg [1:0] clk_s_r;
  reg [1:0] din_s_r;
  reg clk_d_r;

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_s_r <= 2'b11;
      clk_s_r <= 2'b00;
      din_s_r <= 2'b00;
      clk_d_r <= 1'b0;
    end else begin
      sel_s_r <= {sel_s_r[0], sel_b_in};
      clk_s_r <= {clk_s_r[0], sclk_in};
      din_s_r <= {din_s_r[0], sdata_in};
      clk_d_r <= clk_s_r[1];
    end
  end

  wire active = ~sel_s_r[1];
  // Edges only count while selected; an sclk_in phase shorter than one
  // clk_sys_in period may slip through the synchronisers unseen
  wire rise = active & clk_s_r[1] & ~clk_d_r;
  wire fall = active & ~clk_s_r[1] & clk_d_r;
  wire din = din_s_r[1];
  // Data passes as many flops as the clock, so the bit seen at a detected
  // rise is the one the host set up before its pin rise

  assign awake_out = active;

  // ==========================================================
  // Port sequencer
  // ==========================================================
  localparam ST_HUNT = 4'b0001;
  localparam ST_CFG = 4'b0010;
  localparam ST_TURN = 4'b0100;
  localparam ST_SEND = 4'b1000;

  // The fourth falling edge after the start bit: the device takes the
  // shared line here, so the host must already have let go of it
  function take_edge;
    input [3:0] st;
    input seen;
    input [3:0] falls;
    begin
      take_edge = (st == ST_TURN) && seen && (falls == `ASP_TAKE_FALLS);
    end
  endfunction

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [1:0] cfg_r;
  // Whole configuration word as it stands when its last bit arrives
  wire [2:0] cfg_word = {cfg_r, din};
  reg [1:0] cnt_r;
  reg [3:0] fcnt_r;
  reg [4:0] ocnt_r;
  reg drive_r;
  reg out_bit_r;
  wire res_bit;
  reg [2:0] idx;

  // MSB-first then, if bit order is zero, LSB-first trailing bits
  always @* begin
    idx = 3'h0;
    if (ocnt_r < `ASP_OUT_MSB_END) begin
      idx = 3'h7 - ocnt_r[2:0];
    end else begin
      // The trailing run starts at bit 1: bit 0 closed the MSB-first run
      idx = ocnt_r[2:0] + 3'h1;
    end
  end

  // ==========================================================
  // Result store
  // ==========================================================
  asp_result_reg u_res (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .load_in(conv_start_out),
    .data_in(adc_result_in),
    .idx_in(idx),
    .bit_out(res_bit)
  );

  // ==========================================================
  // Next-state decode
  // ==========================================================
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HUNT: begin
        if (rise && din) begin
          state_nxt = ST_CFG;
        end
      end
      ST_CFG: begin
        if (rise && cnt_r == `ASP_CFG_LAST) begin
          state_nxt = ST_TURN;
        end
      end
      ST_TURN: begin
        if (take_edge(state_r, fall, fcnt_r)) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        state_nxt = ST_SEND;
      end
      default: begin
        state_nxt = ST_HUNT;
      end
    endcase
  end

  // ==========================================================
  // Sequencer registers
  // ==========================================================
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_HUNT;
      cfg_r <= 2'h0;
      cnt_r <= 2'd0;
      fcnt_r <= 4'd0;
      ocnt_r <= 5'd0;
      drive_r <= 1'b0;
      out_bit_r <= 1'b0;
      conv_start_out <= 1'b0;
      single_or_differential_out <= 1'b0;
      odd_sign_out <= 1'b0;
      first_bit_order_out <= 1'b0;
      sdata_out <= 1'b0;
      sdata_oe_out <= 1'b0;
    end else if (!active) begin
      // Deselect returns the sequencer to the start-bit search; cfg_r and the config outputs keep their values
      state_r <= ST_HUNT;
      cnt_r <= 2'd0;
      fcnt_r <= 4'd0;
      ocnt_r <= 5'd0;
      drive_r <= 1'b0;
      out_bit_r <= 1'b0;
      conv_start_out <= 1'b0;
      sdata_out <= 1'b0;
      sdata_oe_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      conv_start_out <= 1'b0;
      if (state_r == ST_CFG && rise) begin
        cfg_r <= {cfg_r[0], din};
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == `ASP_CFG_LAST) begin
          single_or_differential_out <= cfg_word[`ASP_CFG_MODE];
          odd_sign_out <= cfg_word[`ASP_CFG_ODD];
          first_bit_order_out <= cfg_word[`ASP_CFG_ORDER];
        end
      end
      // Falling edges count from the start bit until the line is taken
      if ((state_r == ST_CFG || state_r == ST_TURN) && fall) begin
        fcnt_r <= fcnt_r + 4'h1;
      end
      if (take_edge(state_r, fall, fcnt_r)) begin
        // Config word complete: hold the sample and convert while the
        // null bit goes out
        conv_start_out <= 1'b1;
        drive_r <= 1'b1;
        out_bit_r <= 1'b0; // null bit
      end
      if (state_r == ST_SEND && fall) begin
        // Result bits, then zeros for as long as the host keeps clocking
        if (ocnt_r < `ASP_OUT_MSB_END ||
            (!first_bit_order_out && ocnt_r < `ASP_OUT_ALL_END)) begin
          out_bit_r <= res_bit;
          ocnt_r <= ocnt_r + 5'h01;
        end else begin
          out_bit_r <= 1'b0;
        end
      end
      sdata_oe_out <= drive_r | take_edge(state_r, fall, fcnt_r);
      sdata_out <= drive_r & out_bit_r;
    end
  end
endmodule

// ==== tb/asp_serial_port_properties.sv ====
/* Pin checker for the serial port.
   Assumes the bind below. */
`timescale 1ns/1ps
module asp_sp_props (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire sel_b_in,
  input wire sdata_out,
  input wire sdata_oe_out,
  input wire awake_out,
  input wire conv_start_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // ====
  // Properties
  property p_take; conv_start_out |-> $rose(sdata_oe_out); endproperty
  a_take: assert property (p_take) else $error("late take");
  property p_nul; $rose(sdata_oe_out) |-> !sdata_out; endproperty
  a_nul: assert property (p_nul) else $error("no null");
  property p_pls; conv_start_out |=> !conv_start_out; endproperty
  a_pls: assert property (p_pls) else $error("long pulse");
  property p_off; $rose(sel_b_in) |-> ##[1:5] !sdata_oe_out; endproperty
  a_off: assert property (p_off) else $error("held line");
  property p_idl; sel_b_in [*5] |-> !sdata_oe_out && !awake_out; endproperty
  a_idl: assert property (p_idl) else $error("drive idle");
  property p_ign; sel_b_in [*4] |-> !conv_start_out; endproperty
  a_ign: assert property (p_ign) else $error("woke");
  property p_wak; !sel_b_in [*4] |-> awake_out; endproperty
  a_wak: assert property (p_wak) else $error("asleep");
  property p_hld; sdata_oe_out && $changed(sdata_out) |=> $stable(sdata_out) [*3]; endproperty
  a_hld: assert property (p_hld) else $error("short bit");
  c_conv: cover property (conv_start_out);
  c_take: cover property ($rose(sdata_oe_out));
  c_end: cover property ($rose(sel_b_in));
endmodule
bind asp_serial_port asp_sp_props u_props (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .sel_b_in(sel_b_in), .sdata_out(sdata_out), .sdata_oe_out(sdata_oe_out),
  .awake_out(awake_out), .conv_start_out(conv_start_out));

// ==== tb/asp_host_model.sv ====
/* Host pins: select, 400 ns clock, shared data.
   Assumes a 50 ns reference. */
`timescale 1ns/1ps
module asp_host_model (
  input wire clk_in,
  input wire ln_in,
  output logic sel_b_out = 1'b1,
  output logic sclk_out = 1'b0,
  output logic d_out = 1'b0,
  output logic oe_out = 1'b1
);
  // ====
  // Launch while low, sample late in the high phase
  task automatic bit_io(input logic b, input logic rel, output logic r);
    d_out = b;
    repeat (4) @(negedge clk_in);
    sclk_out = 1'b1;
    repeat (4) @(negedge clk_in);
    r = ln_in;
    if (rel)
      oe_out = 1'b0;
    sclk_out = 1'b0;
  endtask
  // Select, wait, clock, deselect at once
  task automatic xfer(input logic [2:0] cfg, output logic [16:0] got);
    logic r;
    oe_out = 1'b1;
    sel_b_out = 1'b0;
    repeat (200) @(negedge clk_in);
    bit_io(1'b0, 1'b0, r);
    bit_io(1'b1, 1'b0, r);
    for (int i = 2; i >= 0; i--)
      bit_io(cfg[i], i == 0, r);
    for (int i = 16; i >= 0; i--) begin
      bit_io(1'b0, 1'b0, r);
      got[i] = r;
    end
    sel_b_out = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask
  // Deliberate misuse: clocks while asleep, cut-short exchange
  task automatic noise;
    logic r;
    repeat (12) bit_io(1'b1, 1'b0, r);
    sel_b_out = 1'b0;
    bit_io(1'b1, 1'b0, r);
    sel_b_out = 1'b1;
    repeat (8) @(negedge clk_in);
  endtask
endmodule

// ==== tb/asp_serial_port_tb.sv ====
/* Bench for the serial port with a host model.
   Assumes the checker binds itself. */
`timescale 1ns/1ps
module asp_serial_port_tb;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] res = 8'h00;
  logic sel_b, sclk, hd, hoe, sd, soe, awake, conv, mode_sd, odd, mo;
  wire ln = soe ? sd : (hoe ? hd : ~sd);
  int n_mismatch = 0;
  int cmp_count = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  asp_serial_port u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sel_b_in(sel_b),
    .sclk_in(sclk), .sdata_in(ln), .adc_result_in(res), .sdata_out(sd), .sdata_oe_out(soe),
    .awake_out(awake), .conv_start_out(conv), .single_or_differential_out(mode_sd),
    .odd_sign_out(odd), .first_bit_order_out(mo));
  asp_host_model u_host (.clk_in(clk_sys_in), .ln_in(ln), .sel_b_out(sel_b),
    .sclk_out(sclk), .d_out(hd), .oe_out(hoe));
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Every configuration, back to back
  task automatic t_modes;
    logic [16:0] got, exp;
    logic [2:0] cf;
    logic aw;
    for (int c = 0; c < 8; c++) begin
      res = 8'h96 + c[7:0];
      exp = {1'b0, res, 8'h00};
      for (int k = 1; k < 8; k++)
        exp[8 - k] = c[0] ? 1'b0 : res[k];
      fork
        u_host.xfer(c[2:0], got);
        @(posedge soe) begin
          cf = {mode_sd, odd, mo};
          aw = awake;
        end
      join
      chk("stream", exp, got);
      chk("awake", 17'h0_0001, {16'h0, aw});
      chk("config", {14'h0, c[2:0]}, {14'h0, cf});
    end
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    u_host.noise();
    chk("asleep", 17'h0_0000, {14'h0, awake, soe, conv});
    t_modes();
    conclude();
  end
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
endmodule
